// ---- src/color_sensor_measure_sequencer.sv ----
// measurement sequencer of a three-channel light sensor with apb registers
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module color_sensor_measure_sequencer
  import color_sensor_pkg::*;
#(
  parameter int conv_unit_cycles  = color_sensor_pkg::CONV_UNIT_CYCLES,
  parameter int pause_step_cycles = color_sensor_pkg::PAUSE_STEP_CYCLES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire color_sensor_pkg::apb_req_t    apb_in,
  output      color_sensor_pkg::apb_rsp_t    apb_out,
  input  wire color_sensor_pkg::light_data_t light_data,
  input  wire logic                          sync_trigger_pin,
  output      logic                          conv_ready
);
  import color_sensor_pkg::*;

  // ----------------------------------------------------------------------
  // reset image and helpers
  // ----------------------------------------------------------------------
  localparam sensor_state_t RESET_STATE = '{
    rsp:                 '0,
    op_state_field:      OP_RESET,
    start_stop_bit:      1'b0,
    power_down:          PD_RESET,
    first_config_reg:    CFG1_RESET,
    second_config_reg:   CFG2_RESET,
    third_config_reg:    CFG3_RESET,
    pause_interval:      PAUSE_RESET,
    stop_edge_count:     EDGES_RESET,
    status:              8'h00,
    results:             '0,
    measured_conv_count: 32'h0000_0000,
    phase:               ph_idle,
    timer:               32'h0000_0000,
    edge_cnt:            8'h00,
    sync_sh:             3'h7,
    eoc:                 1'b1
  };

  function automatic logic [31:0] conv_cycles(input logic [3:0] field);
    conv_cycles = 32'(conv_unit_cycles) << field;
  endfunction

  // config registers only in config state, result registers only for
  // reads in measurement state, the state register always
  function automatic logic acc_ok(input logic [7:0] addr,
                                  input logic       meas,
                                  input logic       wr);
    case (addr)
      OFF_OSR:                                     acc_ok = 1'b1;
      OFF_CFG1, OFF_CFG2, OFF_CFG3,
      OFF_PAUSE, OFF_EDGES:                        acc_ok = !meas;
      OFF_STATUS, OFF_RES_X, OFF_RES_Y,
      OFF_RES_Z, OFF_MCOUNT:                       acc_ok = meas && !wr;
      default:                                     acc_ok = 1'b0;
    endcase
  endfunction

  sensor_state_t st;
  sensor_state_t next_st;
  meas_mode_t    mode;
  logic          meas;
  logic          fall;
  logic          setup;
  logic          commit;
  logic          wr_ok;
  logic          rd_ok;
  logic          conv_end;
  logic [31:0]   rd_word;
  logic [31:0]   pause_load;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st    = st;
    meas       = (st.op_state_field == OP_MEASURE);
    mode       = meas_mode_t'(st.third_config_reg[MODE_LSB +: 2]);
    fall       = st.sync_sh[2] & ~st.sync_sh[1];
    next_st.sync_sh = {st.sync_sh[1:0], sync_trigger_pin};
    pause_load = 32'(st.pause_interval) * 32'(pause_step_cycles);
    conv_end   = 1'b0;

    // apb: pready is registered, so every access phase lasts two cycles
    setup  = apb_in.psel & apb_in.penable & ~st.rsp.pready;
    commit = apb_in.psel & apb_in.penable & st.rsp.pready;
    wr_ok  = commit & apb_in.pwrite & ~st.rsp.pslverr;
    rd_ok  = commit & ~apb_in.pwrite & ~st.rsp.pslverr;
    case (apb_in.paddr)
      OFF_OSR:    rd_word = {24'h0, st.start_stop_bit, st.power_down,
                             3'h0, st.op_state_field};
      OFF_CFG1:   rd_word = {24'h0, st.first_config_reg};
      OFF_CFG2:   rd_word = {24'h0, st.second_config_reg};
      OFF_CFG3:   rd_word = {24'h0, st.third_config_reg};
      OFF_PAUSE:  rd_word = {24'h0, st.pause_interval};
      OFF_EDGES:  rd_word = {24'h0, st.stop_edge_count};
      OFF_STATUS: rd_word = {24'h0, st.status[7:1], st.phase == ph_conv};
      OFF_RES_X:  rd_word = {16'h0, st.results.x};
      OFF_RES_Y:  rd_word = {16'h0, st.results.y};
      OFF_RES_Z:  rd_word = {16'h0, st.results.z};
      OFF_MCOUNT: rd_word = st.measured_conv_count;
      default:    rd_word = 32'h0000_0000;
    endcase
    next_st.rsp.pready  = setup;
    next_st.rsp.pslverr = 1'b0;
    if (setup) begin
      next_st.rsp.pslverr = ~acc_ok(apb_in.paddr, meas, apb_in.pwrite);
      next_st.rsp.prdata  = acc_ok(apb_in.paddr, meas, apb_in.pwrite) ?
                            rd_word : 32'h0000_0000;
    end

    // status read clears sticky flags; a set below in the same cycle wins
    if (rd_ok && apb_in.paddr == OFF_STATUS) begin
      next_st.status[STAT_DONE] = 1'b0;
      next_st.status[STAT_OVER] = 1'b0;
    end

    // sequencer
    case (st.phase)
      ph_idle: begin
        if (meas && st.start_stop_bit) begin
          if (mode == continuous_mode || mode == single_shot_mode ||
              fall) begin
            next_st.phase    = ph_conv;
            next_st.eoc      = 1'b0;
            next_st.edge_cnt = 8'h00;
            next_st.timer    = (mode == sync_start_stop_mode) ? 32'h0 :
              conv_cycles(st.first_config_reg[CTIME_LSB +: 4]);
            if (mode == continuous_mode) begin
              next_st.power_down = 1'b0;
              next_st.third_config_reg[STANDBY_BIT] = 1'b0;
            end
          end
        end
      end
      ph_conv: begin
        if (!meas || !st.start_stop_bit) begin
          next_st.phase = ph_idle;
          next_st.eoc   = 1'b1;
        end else if (mode == sync_start_stop_mode) begin
          next_st.timer = st.timer + 32'h1;
          if (fall) begin
            if ({1'b0, st.edge_cnt} + 9'h001 >=
                {1'b0, st.stop_edge_count}) begin
              conv_end = 1'b1;
            end else begin
              next_st.edge_cnt = st.edge_cnt + 8'h01;
            end
          end
        end else if (st.timer <= 32'h1) begin
          conv_end = 1'b1;
        end else begin
          next_st.timer = st.timer - 32'h1;
        end
        if (conv_end) begin
          next_st.results           = light_data;
          next_st.eoc               = 1'b1;
          next_st.status[STAT_DONE] = 1'b1;
          if (st.status[STAT_DONE]) begin
            next_st.status[STAT_OVER] = 1'b1;
          end
          if (mode == sync_start_stop_mode &&
              st.second_config_reg[TM_EN_BIT]) begin
            next_st.measured_conv_count = st.timer + 32'h1;
          end
          if (mode == single_shot_mode) begin
            next_st.phase          = ph_idle;
            next_st.start_stop_bit = 1'b0;
          end else if (st.pause_interval != 8'h00) begin
            next_st.phase = ph_pause;
            next_st.timer = pause_load;
          end else begin
            next_st.phase = ph_idle;
          end
        end
      end
      ph_pause: begin
        // trigger edges are simply not looked at here
        if (!meas || !st.start_stop_bit || st.timer <= 32'h1) begin
          next_st.phase = ph_idle;
        end else begin
          next_st.timer = st.timer - 32'h1;
        end
      end
      default: begin
        next_st.phase = ph_idle;
        next_st.eoc   = 1'b1;
      end
    endcase

    // writes land on the completing edge only, after the sequencer, so a
    // host write of start_stop_bit beats the self-clear of the same cycle
    if (wr_ok) begin
      case (apb_in.paddr)
        OFF_OSR: begin
          next_st.start_stop_bit = apb_in.pwdata[SS_BIT];
          next_st.power_down     = apb_in.pwdata[PD_BIT];
          if (apb_in.pwdata[2:0] == OP_MEASURE) begin
            next_st.op_state_field = OP_MEASURE;
          end else if (apb_in.pwdata[2:0] == OP_CONFIG) begin
            next_st.op_state_field = OP_CONFIG;
            if (meas) begin
              next_st.phase               = ph_idle;
              next_st.eoc                 = 1'b1;
              next_st.status              = 8'h00;
              next_st.results             = '0;
              next_st.measured_conv_count = 32'h0000_0000;
            end
          end
        end
        OFF_CFG1:  next_st.first_config_reg  = apb_in.pwdata[7:0];
        OFF_CFG2:  next_st.second_config_reg = apb_in.pwdata[7:0];
        OFF_CFG3:  next_st.third_config_reg  = apb_in.pwdata[7:0];
        OFF_PAUSE: next_st.pause_interval    = apb_in.pwdata[7:0];
        OFF_EDGES: next_st.stop_edge_count   = apb_in.pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= RESET_STATE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign apb_out    = st.rsp;
  assign conv_ready = st.eoc;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking chk_cb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (reset);

  sequence cfg_access_s;
    meas && setup && !apb_in.pwrite &&
    (apb_in.paddr == OFF_CFG1 || apb_in.paddr == OFF_PAUSE);
  endsequence

  sequence single_end_s;
    conv_end && mode == single_shot_mode && !wr_ok;
  endsequence

  sequence pause_last_s;
    st.phase == ph_pause && st.timer == 32'h1 && meas &&
    st.start_stop_bit && mode == continuous_mode && !wr_ok;
  endsequence

  eoc_low_conv_a: assert property (st.phase == ph_conv |-> !st.eoc)
    else $error("end-of-conversion high during conversion");

  eoc_rise_end_a: assert property ($rose(st.eoc) |->
      $past(st.phase) == ph_conv)
    else $error("end-of-conversion rose outside conversion end");

  config_no_meas_a: assert property (!meas && !wr_ok |=>
      st.phase == ph_idle)
    else $error("measurement running in config state");

  cfg_refused_a: assert property (cfg_access_s |=>
      st.rsp.pready && st.rsp.pslverr && st.rsp.prdata == 32'h0)
    else $error("config register reachable in measurement state");

  leave_clears_a: assert property ($past(meas) && !meas |->
      st.phase == ph_idle && st.status == 8'h00 && st.results == '0)
    else $error("leaving measurement did not clear");

  single_self_clear_a: assert property (single_end_s |=>
      !st.start_stop_bit && st.phase == ph_idle)
    else $error("single-shot did not clear start bit");

  pause_load_a: assert property (conv_end && mode != single_shot_mode &&
      st.pause_interval != 8'h00 && !wr_ok |=>
      st.phase == ph_pause && st.timer == $past(pause_load))
    else $error("pause not loaded after conversion");

  pause_ignores_a: assert property (st.phase == ph_pause && fall |=>
      st.phase != ph_conv)
    else $error("trigger edge started conversion in pause");

  sync_start_mode_gate_a: assert property (st.phase == ph_idle && !st.start_stop_bit
      && meas && fall |=> st.phase == ph_idle)
    else $error("trigger accepted with start bit clear");

  continuous_mode_restart_a: assert property (pause_last_s |=> ##1
      st.phase == ph_conv && !st.eoc)
    else $error("continuous mode did not restart after pause");

endmodule

// ---- src/color_sensor_pkg.sv ----
// shared constants and types of the colour sensor measurement sequencer
package color_sensor_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ           = 10;
  localparam int PAUSE_STEP_US     = 8;
  localparam int PAUSE_MAX_US      = 2040;
  localparam int PAUSE_STEP_CYCLES = PAUSE_STEP_US * CLK_MHZ;
  localparam int CONV_UNIT_US      = 1000;
  localparam int CONV_UNIT_CYCLES  = CONV_UNIT_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_OSR    = 8'h00;
  localparam logic [7:0] OFF_CFG1   = 8'h04;
  localparam logic [7:0] OFF_CFG2   = 8'h08;
  localparam logic [7:0] OFF_CFG3   = 8'h0C;
  localparam logic [7:0] OFF_PAUSE  = 8'h10;
  localparam logic [7:0] OFF_EDGES  = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RES_X  = 8'h1C;
  localparam logic [7:0] OFF_RES_Y  = 8'h20;
  localparam logic [7:0] OFF_RES_Z  = 8'h24;
  localparam logic [7:0] OFF_MCOUNT = 8'h28;

  // ----------------------------------------------------------------------
  // fields, codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_NOP      = 3'h0;
  localparam logic [2:0] OP_CONFIG   = 3'h2;
  localparam logic [2:0] OP_MEASURE  = 3'h3;
  localparam int         SS_BIT      = 7;
  localparam int         PD_BIT      = 6;
  localparam int         MODE_LSB    = 6;
  localparam int         STANDBY_BIT = 4;
  localparam int         TM_EN_BIT   = 3;
  localparam int         CTIME_LSB   = 0;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_DONE   = 1;
  localparam int         STAT_OVER   = 2;
  localparam logic [2:0] OP_RESET    = OP_CONFIG;
  localparam logic       PD_RESET    = 1'b1;
  localparam logic [7:0] CFG1_RESET  = 8'h00;
  localparam logic [7:0] CFG2_RESET  = 8'h00;
  localparam logic [7:0] CFG3_RESET  = 8'h40;
  localparam logic [7:0] PAUSE_RESET = 8'h00;
  localparam logic [7:0] EDGES_RESET = 8'h01;

  typedef enum logic [1:0] {
    continuous_mode      = 2'b00,
    single_shot_mode     = 2'b01,
    sync_start_mode      = 2'b10,
    sync_start_stop_mode = 2'b11
  } meas_mode_t;

  typedef enum logic [1:0] {
    ph_idle  = 2'b00,
    ph_conv  = 2'b01,
    ph_pause = 2'b10
  } phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } light_data_t;

  typedef struct packed {
    apb_rsp_t    rsp;
    logic [2:0]  op_state_field;
    logic        start_stop_bit;
    logic        power_down;
    logic [7:0]  first_config_reg;
    logic [7:0]  second_config_reg;
    logic [7:0]  third_config_reg;
    logic [7:0]  pause_interval;
    logic [7:0]  stop_edge_count;
    logic [7:0]  status;
    light_data_t results;
    logic [31:0] measured_conv_count;
    phase_t      phase;
    logic [31:0] timer;
    logic [7:0]  edge_cnt;
    logic [2:0]  sync_sh;
    logic        eoc;
  } sensor_state_t;

endpackage

// ---- verif/trigger_source.sv ----
// trigger source model that drives falling edges onto the sync pin
`timescale 1ns/1ns
module trigger_source (
  output logic sync_trigger_pin
);
  // ----------------------------------------------------------------------
  // pulse train
  // ----------------------------------------------------------------------
  // pin idles high between bursts, so a stale low never looks like an edge
  initial sync_trigger_pin = 1'b1;

  // link period 800 ns, half low and half high
  task automatic fire(input int n);
    repeat (n) begin
      sync_trigger_pin = 1'b0;
      #400;
      sync_trigger_pin = 1'b1;
      #400;
    end
  endtask
endmodule

// ---- verif/color_sensor_measure_sequencer_bench.sv ----
// self-checking bench of the colour sensor measurement sequencer
`timescale 1ns/1ns
module color_sensor_measure_sequencer_bench;
  import color_sensor_pkg::*;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] ed;
    logic        ee;
  } row_t;

  logic        sys_clk;
  logic        reset;
  logic        clk_en;
  apb_req_t    apb_in;
  apb_rsp_t    apb_out;
  light_data_t light_data;
  logic        sync_trigger_pin;
  logic        conv_ready;
  logic        prev_rdy;
  int          error_cnt;
  int          total_checks;
  int          fall_cnt;
  int          fc;
  int          n;

  // ----------------------------------------------------------------------
  // table: reset values, access refusal in config, config read-back
  // ----------------------------------------------------------------------
  row_t rows [19] = '{
    '{1'b0, OFF_OSR,    32'h0,  32'h42, 1'b0},
    '{1'b0, OFF_CFG1,   32'h0,  32'h00, 1'b0},
    '{1'b0, OFF_CFG3,   32'h0,  32'h40, 1'b0},
    '{1'b0, OFF_EDGES,  32'h0,  32'h01, 1'b0},
    '{1'b0, OFF_PAUSE,  32'h0,  32'h00, 1'b0},
    '{1'b0, OFF_CFG2,   32'h0,  32'h00, 1'b0},
    '{1'b0, OFF_STATUS, 32'h0,  32'h00, 1'b1},
    '{1'b0, OFF_RES_X,  32'h0,  32'h00, 1'b1},
    '{1'b0, OFF_MCOUNT, 32'h0,  32'h00, 1'b1},
    '{1'b1, OFF_STATUS, 32'h1,  32'h00, 1'b1},
    '{1'b0, 8'h2C,      32'h0,  32'h00, 1'b1},
    '{1'b1, OFF_PAUSE,  32'h0A, 32'h00, 1'b0},
    '{1'b0, OFF_PAUSE,  32'h0,  32'h0A, 1'b0},
    '{1'b1, OFF_EDGES,  32'h03, 32'h00, 1'b0},
    '{1'b0, OFF_EDGES,  32'h0,  32'h03, 1'b0},
    '{1'b1, OFF_CFG2,   32'h08, 32'h00, 1'b0},
    '{1'b0, OFF_CFG2,   32'h0,  32'h08, 1'b0},
    '{1'b1, OFF_OSR,    32'h02, 32'h00, 1'b0},
    '{1'b0, OFF_OSR,    32'h0,  32'h02, 1'b0}
  };

  color_sensor_measure_sequencer #(
    .conv_unit_cycles  (4),
    .pause_step_cycles (4)
  ) DUT (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .clk_en           (clk_en),
    .apb_in           (apb_in),
    .apb_out          (apb_out),
    .light_data       (light_data),
    .sync_trigger_pin (sync_trigger_pin),
    .conv_ready       (conv_ready)
  );

  trigger_source trig (
    .sync_trigger_pin (sync_trigger_pin)
  );

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (prev_rdy === 1'b1 && conv_ready === 1'b0) fall_cnt++;
    prev_rdy = conv_ready;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang;
    error_cnt++;
    print_verdict();
  endtask

  // one apb transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    int k;
    @(posedge sys_clk);
    apb_in <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge sys_clk);
    apb_in.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (apb_out.pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    apb_in <= '0;
    if (!w) check(apb_out.prdata, ed);
    check({31'h0, apb_out.pslverr}, {31'h0, ee});
  endtask

  task automatic hold(input logic v, output int c);
    c = 0;
    while (conv_ready === v && c < 5000) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 5000) hang();
  endtask

  // length of the next low phase of conv_ready
  task automatic low_len(output int c);
    hold(1'b1, c);
    hold(1'b0, c);
  endtask

  // pin edges placed mid-cycle, clear of the sampling edge
  task automatic pulse(input int k);
    #30;
    trig.fire(k);
    @(posedge sys_clk);
  endtask

  task automatic quiet(input int cyc, input int exp);
    repeat (cyc) @(posedge sys_clk);
    check(32'(fall_cnt), 32'(exp));
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    apb_in = '0;
    prev_rdy = 1'b1;
    light_data = '{x:16'h1357, y:16'h2468, z:16'h0ACE};
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) apb(rows[i].w, rows[i].a, rows[i].d, rows[i].ed, rows[i].ee);
    check({31'h0, conv_ready}, 32'h1);
    // single-shot from config with one write
    apb(1'b1, OFF_OSR, 32'h83, 32'h0, 1'b0);
    low_len(n);
    check(32'(n), 32'h4);
    apb(1'b0, OFF_OSR, 32'h0, 32'h03, 1'b0);
    apb(1'b0, OFF_RES_X, 32'h0, 32'h1357, 1'b0);
    apb(1'b0, OFF_RES_Z, 32'h0, 32'h0ACE, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0, 32'h02, 1'b0);
    apb(1'b0, OFF_CFG1, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFF_CFG1, 32'h5, 32'h0, 1'b1);
    apb(1'b1, OFF_OSR, 32'h00, 32'h0, 1'b0);
    apb(1'b0, OFF_OSR, 32'h0, 32'h03, 1'b0);
    fc = fall_cnt;
    apb(1'b1, OFF_OSR, 32'h80, 32'h0, 1'b0);
    low_len(n);
    check(32'(n), 32'h4);
    quiet(30, fc + 1);
    // continuous with power-down and standby set
    apb(1'b1, OFF_OSR, 32'h42, 32'h0, 1'b0);
    apb(1'b0, OFF_CFG1, 32'h0, 32'h00, 1'b0);
    apb(1'b1, OFF_CFG1, 32'h01, 32'h0, 1'b0);
    apb(1'b1, OFF_CFG3, 32'h10, 32'h0, 1'b0);
    apb(1'b1, OFF_OSR, 32'hC3, 32'h0, 1'b0);
    low_len(n);
    check(32'(n), 32'h8);
    hold(1'b1, n);
    check(32'(n >= 40 && n <= 43), 32'h1);
    hold(1'b0, n);
    check(32'(n), 32'h8);
    apb(1'b0, OFF_OSR, 32'h0, 32'h83, 1'b0);
    apb(1'b1, OFF_OSR, 32'h03, 32'h0, 1'b0);
    fc = fall_cnt;
    quiet(100, fc);
    // abort mid-conversion by going back to config
    apb(1'b1, OFF_OSR, 32'h83, 32'h0, 1'b0);
    hold(1'b1, n);
    apb(1'b1, OFF_OSR, 32'h02, 32'h0, 1'b0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, conv_ready}, 32'h1);
    apb(1'b0, OFF_CFG3, 32'h0, 32'h00, 1'b0);
    apb(1'b1, OFF_OSR, 32'h03, 32'h0, 1'b0);
    apb(1'b0, OFF_RES_X, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0, 32'h0, 1'b0);
    // sync-start: start bit, pause masking
    apb(1'b1, OFF_OSR, 32'h02, 32'h0, 1'b0);
    apb(1'b1, OFF_CFG1, 32'h00, 32'h0, 1'b0);
    apb(1'b1, OFF_CFG3, 32'h80, 32'h0, 1'b0);
    apb(1'b1, OFF_OSR, 32'h03, 32'h0, 1'b0);
    fc = fall_cnt;
    pulse(1);
    quiet(20, fc);
    apb(1'b1, OFF_OSR, 32'h83, 32'h0, 1'b0);
    pulse(3);
    quiet(60, fc + 1);
    pulse(1);
    quiet(20, fc + 2);
    // sync-start/stop with duration capture, three counted edges
    apb(1'b1, OFF_OSR, 32'h02, 32'h0, 1'b0);
    apb(1'b1, OFF_CFG3, 32'hC0, 32'h0, 1'b0);
    apb(1'b1, OFF_OSR, 32'h83, 32'h0, 1'b0);
    fc = fall_cnt;
    pulse(4);
    quiet(20, fc + 1);
    check({31'h0, conv_ready}, 32'h1);
    apb(1'b0, OFF_MCOUNT, 32'h0, 32'h18, 1'b0);
    print_verdict();
  end
endmodule
